/* pkg/tsc_pkg.sv */
// Shared constants and types of the temperature sensor control block
package tsc_pkg;

    // ========================================================
    // Register select codes
    localparam logic [1:0] SEL_TEMP = 2'h0;
    localparam logic [1:0] SEL_CFG  = 2'h1;
    localparam logic [1:0] SEL_LOW  = 2'h2;
    localparam logic [1:0] SEL_HIGH = 2'h3;
    localparam logic [7:0] PTR_RST  = 8'h00;

    // ========================================================
    // Configuration fields, bit positions within the 16-bit word
    localparam int CFG_OS    = 15;
    localparam int CFG_RES_H = 14;
    localparam int CFG_RES_L = 13;
    localparam int CFG_FQ_H  = 12;
    localparam int CFG_FQ_L  = 11;
    localparam int CFG_POL   = 10;
    localparam int CFG_TM    = 9;
    localparam int CFG_SD    = 8;
    localparam int CFG_CR_H  = 7;
    localparam int CFG_CR_L  = 6;
    localparam int CFG_AL    = 5;
    localparam int CFG_EM    = 4;

    // ========================================================
    // Reset values
    localparam logic [15:0] CFG_RST  = 16'h60A0;
    localparam logic [15:0] LOW_RST  = 16'h4B00;  // 75 degrees
    localparam logic [15:0] HIGH_RST = 16'h5000;  // 80 degrees
    localparam logic [1:0]  RES_FIX  = 2'h3;

    // ========================================================
    // Fault queue depths
    localparam logic [2:0] FQ_N0  = 3'h1;
    localparam logic [2:0] FQ_N1  = 3'h2;
    localparam logic [2:0] FQ_N2  = 3'h4;
    localparam logic [2:0] FQ_N3  = 3'h6;

    // ========================================================
    // Timing
    localparam int CNT_W        = 28;
    localparam int CLK_KHZ      = 50_000;
    localparam int CONV_TIME_US = 26_000;
    localparam int RATE0_MS     = 4000;   // 0.25 Hz
    localparam int RATE1_MS     = 1000;   // 1 Hz
    localparam int RATE2_MS     = 250;    // 4 Hz
    localparam int RATE3_MS     = 125;    // 8 Hz
    localparam logic [CNT_W-1:0] CONV_CYC  =
        CNT_W'(CONV_TIME_US * CLK_KHZ / 1000);
    localparam logic [CNT_W-1:0] RATE0_CYC = CNT_W'(RATE0_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] RATE1_CYC = CNT_W'(RATE1_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] RATE2_CYC = CNT_W'(RATE2_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] RATE3_CYC = CNT_W'(RATE3_MS * CLK_KHZ);
    localparam logic [CNT_W-1:0] TMR_LAT   = CNT_W'(2);  // Load plus done

    // ========================================================
    // Conversion sequencer states
    typedef enum logic [1:0]
    {
        ST_CONV = 2'b00,
        ST_WAIT = 2'b01,
        ST_OFF  = 2'b10
    } tsc_state_t;

endpackage

/* pkg/tsc_tmr_if.sv */
// Carrier between the sequencer and the conversion timer
`timescale 1ns/1ps
`default_nettype none
interface tsc_tmr_if;
    logic                      load;
    logic [tsc_pkg::CNT_W-1:0] count;
    logic                      done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

/* rtl/tsc_conv_timer.sv */
// Down counter that times conversions and idle delays
`timescale 1ns/1ps
`default_nettype none
module tsc_conv_timer
(
    input  wire logic   clk,
    input  wire logic   rst,
    tsc_tmr_if.tmr      t
);

    logic [tsc_pkg::CNT_W-1:0] cnt_q;

    // ========================================================
    // Load, count down, pulse done on the last cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q  <= '0;
            t.done <= 1'b0;
        end
        else
        begin
            t.done <= 1'b0;
            if (t.load)
                cnt_q <= t.count;
            else if (cnt_q != '0)
            begin
                cnt_q <= cnt_q - tsc_pkg::CNT_W'(1);
                if (cnt_q == tsc_pkg::CNT_W'(1))
                    t.done <= 1'b1;  // Interval expired
            end
        end
    end

endmodule
`default_nettype wire

/* rtl/tsc_sensor_ctl.sv */
// Temperature sensor conversion sequencer, register file and alert logic
//
// Summary of operation
// R1: After reset or general-call reset a conversion starts at once, 26 ms.
// R2: Rate bits pick 0.25, 1, 4 (default) or 8 Hz; idle between.
// R3: Extended bit picks 13-bit instead of 12-bit for result and limits.
// R4: Shutdown bit ends current conversion then stops; clear keeps converting.
// R5: One-shot write in shutdown runs one conversion; bit reads 0 then 1.
// R6: Each conversion lasts 26 ms.
// R7: Comparator mode: alert at or above high, holds until below low.
// R8: Interrupt mode: alert on crossing a limit, cleared by result read.
// R9: Eight-bit select byte, low two bits pick register, reset to 00.
// R10: Select 0 result, 1 configuration, 2 low limit, 3 high limit.
// R11: Host writes zeros into the upper six select bits.
// R12: Result holds latest conversion, read MSB byte then LSB byte.
// R13: Value left-justified; extended format sets bit 0 of second byte.
// R14: A read may stop after the first result byte.
// R15: Configuration is 16 bits with fixed layout, reset 0x60A0.
// R16: Registers update byte by byte; one-byte write changes only MSB.
// R17: Polarity 0 gives active-low alert, 1 gives active-high.
// R18: Alert needs 1, 2, 4 or 6 consecutive faults per queue field.
// R19: Resolution bits read-only, fixed at 11.
// R20: Alert status bit follows comparator behaviour, inverted by polarity.
// R21: Conversion and delay times counted on the core clock.
`timescale 1ns/1ps
`default_nettype none
module tsc_sensor_ctl
#(
    parameter logic [tsc_pkg::CNT_W-1:0] CONV_CYCLES = tsc_pkg::CONV_CYC,
    parameter logic [tsc_pkg::CNT_W-1:0] RATE0_CYCLES = tsc_pkg::RATE0_CYC,
    parameter logic [tsc_pkg::CNT_W-1:0] RATE1_CYCLES = tsc_pkg::RATE1_CYC,
    parameter logic [tsc_pkg::CNT_W-1:0] RATE2_CYCLES = tsc_pkg::RATE2_CYC,
    parameter logic [tsc_pkg::CNT_W-1:0] RATE3_CYCLES = tsc_pkg::RATE3_CYC
)
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic        GC_RESET,
    input  wire logic        WR_STB,
    input  wire logic        WR_PTR,
    input  wire logic [7:0]  WR_DATA,
    input  wire logic        RD_STB,
    input  wire logic        RD_FIRST,
    input  wire logic [12:0] TEMP_IN,
    output logic      [7:0]  RD_DATA,
    output logic             ALERT,
    output logic             CONV_BUSY
);

    // ========================================================
    // Declarations
    logic                 rst;
    logic [12:0]          tin_m_q, tin_s_q;
    logic [7:0]           ptr_q;
    logic [1:0]           wr_idx_q;
    logic                 wr_msb, wr_lsb, os_wr, rd_temp;
    logic                 os_q, pol_q, tm_q, sd_q, em_q;
    logic [1:0]           fq_q, rate_q;
    logic [15:0]          low_q, high_q;
    logic [12:0]          temp_q;
    logic                 oneshot_q;
    tsc_pkg::tsc_state_t  st_q;
    logic                 ld_q;
    logic [tsc_pkg::CNT_W-1:0] ld_cnt_q;
    logic                 conv_done;
    logic signed [12:0]   t_new;
    logic [2:0]           hi_cnt_q, lo_cnt_q, hi_cnt_d, lo_cnt_d, need;
    logic                 hi_trip, lo_trip;
    logic                 cmp_q, int_q, arm_lo_q;
    logic [15:0]          rd_word;

    tsc_tmr_if tmr_if ();

    assign rst = !RST_N || GC_RESET;  // General call resets like power-up

    // ========================================================
    // Functions
    // Limit register to a signed value in the selected format
    function automatic logic signed [12:0] lim_val(input logic [15:0] r,
                                                   input logic em);
        lim_val = em ? r[15:3] : {r[15], r[15:4]};  // R3
    endfunction

    // Fault queue field to required consecutive count
    function automatic logic [2:0] fq_need(input logic [1:0] f);
        case (f)
            2'h0:    fq_need = tsc_pkg::FQ_N0;
            2'h1:    fq_need = tsc_pkg::FQ_N1;
            2'h2:    fq_need = tsc_pkg::FQ_N2;
            default: fq_need = tsc_pkg::FQ_N3;
        endcase
    endfunction

    // Idle time between conversions for each rate code
    function automatic logic [tsc_pkg::CNT_W-1:0] gap_cyc(input logic [1:0] r);
        case (r)
            2'h0:    gap_cyc = RATE0_CYCLES - CONV_CYCLES;
            2'h1:    gap_cyc = RATE1_CYCLES - CONV_CYCLES;
            2'h2:    gap_cyc = RATE2_CYCLES - CONV_CYCLES;
            default: gap_cyc = RATE3_CYCLES - CONV_CYCLES;
        endcase
        gap_cyc = gap_cyc - tsc_pkg::TMR_LAT;  // Timer adds two cycles
    endfunction

    // ========================================================
    // Sensor sample synchroniser
    always_ff @(posedge CORE_CLK)
    begin
        tin_m_q <= TEMP_IN;
        tin_s_q <= tin_m_q;
    end

    // ========================================================
    // Select byte and data byte position
    always_ff @(posedge CORE_CLK)
    begin
        if (rst)
        begin
            ptr_q    <= tsc_pkg::PTR_RST;  // R9
            wr_idx_q <= 2'h0;
        end
        else if (WR_STB)
        begin
            if (WR_PTR)
            begin
                ptr_q    <= WR_DATA;  // R9
                wr_idx_q <= 2'h0;
            end
            else if (wr_idx_q != 2'h2)
                wr_idx_q <= wr_idx_q + 2'h1;
        end
    end

    // Byte strobes; bytes past the second are ignored
    assign wr_msb  = WR_STB && !WR_PTR && (wr_idx_q == 2'h0);  // R16
    assign wr_lsb  = WR_STB && !WR_PTR && (wr_idx_q == 2'h1);  // R16
    assign os_wr   = wr_msb && (ptr_q[1:0] == tsc_pkg::SEL_CFG)
                     && WR_DATA[tsc_pkg::CFG_OS - 8];
    assign rd_temp = RD_STB && RD_FIRST
                     && (ptr_q[1:0] == tsc_pkg::SEL_TEMP);

    // ========================================================
    // Configuration fields
    always_ff @(posedge CORE_CLK)
    begin
        if (rst)
        begin
            fq_q   <= tsc_pkg::CFG_RST[tsc_pkg::CFG_FQ_H:tsc_pkg::CFG_FQ_L];
            pol_q  <= tsc_pkg::CFG_RST[tsc_pkg::CFG_POL];
            tm_q   <= tsc_pkg::CFG_RST[tsc_pkg::CFG_TM];
            sd_q   <= tsc_pkg::CFG_RST[tsc_pkg::CFG_SD];
            rate_q <= tsc_pkg::CFG_RST[tsc_pkg::CFG_CR_H:tsc_pkg::CFG_CR_L];
            em_q   <= tsc_pkg::CFG_RST[tsc_pkg::CFG_EM];  // R15
        end
        else if (ptr_q[1:0] == tsc_pkg::SEL_CFG)  // R10
        begin
            if (wr_msb)
            begin
                fq_q  <= WR_DATA[tsc_pkg::CFG_FQ_H-8:tsc_pkg::CFG_FQ_L-8];
                pol_q <= WR_DATA[tsc_pkg::CFG_POL-8];
                tm_q  <= WR_DATA[tsc_pkg::CFG_TM-8];
                sd_q  <= WR_DATA[tsc_pkg::CFG_SD-8];
            end
            if (wr_lsb)
            begin
                rate_q <= WR_DATA[tsc_pkg::CFG_CR_H:tsc_pkg::CFG_CR_L];
                em_q   <= WR_DATA[tsc_pkg::CFG_EM];
            end
        end
    end

    // ========================================================
    // Limit registers, one byte at a time
    always_ff @(posedge CORE_CLK)
    begin
        if (rst)
        begin
            low_q  <= tsc_pkg::LOW_RST;
            high_q <= tsc_pkg::HIGH_RST;
        end
        else
        begin
            if (ptr_q[1:0] == tsc_pkg::SEL_LOW && wr_msb)
                low_q[15:8] <= WR_DATA;  // R16
            if (ptr_q[1:0] == tsc_pkg::SEL_LOW && wr_lsb)
                low_q[7:0] <= WR_DATA;
            if (ptr_q[1:0] == tsc_pkg::SEL_HIGH && wr_msb)
                high_q[15:8] <= WR_DATA;  // R16
            if (ptr_q[1:0] == tsc_pkg::SEL_HIGH && wr_lsb)
                high_q[7:0] <= WR_DATA;
        end
    end

    // ========================================================
    // Conversion sequencer
    assign conv_done     = (st_q == tsc_pkg::ST_CONV) && tmr_if.done && !ld_q;
    assign tmr_if.load   = ld_q;
    assign tmr_if.count  = ld_cnt_q;

    always_ff @(posedge CORE_CLK)
    begin
        if (rst)
        begin
            st_q      <= tsc_pkg::ST_CONV;  // R1
            ld_q      <= 1'b1;
            ld_cnt_q  <= CONV_CYCLES - tsc_pkg::TMR_LAT;  // R6
            oneshot_q <= 1'b0;
            os_q      <= tsc_pkg::CFG_RST[tsc_pkg::CFG_OS];
        end
        else
        begin
            ld_q <= 1'b0;
            case (st_q)
                tsc_pkg::ST_CONV:
                begin
                    if (conv_done)
                    begin
                        oneshot_q <= 1'b0;
                        if (oneshot_q)
                            os_q <= 1'b1;  // R5
                        if (sd_q)
                            st_q <= tsc_pkg::ST_OFF;  // R4
                        else
                        begin
                            st_q     <= tsc_pkg::ST_WAIT;
                            ld_q     <= 1'b1;
                            ld_cnt_q <= gap_cyc(rate_q);  // R2 R21
                        end
                    end
                end
                tsc_pkg::ST_WAIT:
                begin
                    if (sd_q)
                        st_q <= tsc_pkg::ST_OFF;  // R4
                    else if (tmr_if.done)
                    begin
                        st_q     <= tsc_pkg::ST_CONV;  // R2
                        ld_q     <= 1'b1;
                        ld_cnt_q <= CONV_CYCLES - tsc_pkg::TMR_LAT;
                    end
                end
                tsc_pkg::ST_OFF:
                begin
                    if (!sd_q || os_wr)
                    begin
                        st_q      <= tsc_pkg::ST_CONV;  // R4 R5
                        ld_q      <= 1'b1;
                        ld_cnt_q  <= CONV_CYCLES - tsc_pkg::TMR_LAT;
                        oneshot_q <= sd_q;
                        if (sd_q)
                            os_q <= 1'b0;  // R5
                    end
                end
                default:
                    st_q <= tsc_pkg::ST_CONV;
            endcase
        end
    end

    tsc_conv_timer u_timer
    (
        .clk (CORE_CLK),
        .rst (rst),
        .t   (tmr_if.tmr)
    );

    // ========================================================
    // New sample, limit compares and fault counts
    always_comb
    begin
        t_new    = em_q ? tin_s_q : {tin_s_q[11], tin_s_q[11:0]};  // R3
        need     = fq_need(fq_q);
        hi_cnt_d = (t_new >= lim_val(high_q, em_q)) ?
                   ((hi_cnt_q == 3'h6) ? 3'h6 : hi_cnt_q + 3'h1) : 3'h0;
        lo_cnt_d = (t_new < lim_val(low_q, em_q)) ?
                   ((lo_cnt_q == 3'h6) ? 3'h6 : lo_cnt_q + 3'h1) : 3'h0;
        hi_trip  = hi_cnt_d >= need;  // R18
        lo_trip  = lo_cnt_d >= need;  // R18
    end

    // Result latch, fault counters and comparator state
    always_ff @(posedge CORE_CLK)
    begin
        if (rst)
        begin
            temp_q   <= 13'h0000;
            hi_cnt_q <= 3'h0;
            lo_cnt_q <= 3'h0;
            cmp_q    <= 1'b0;
        end
        else if (conv_done)
        begin
            temp_q   <= t_new;  // R12
            hi_cnt_q <= hi_cnt_d;
            lo_cnt_q <= lo_cnt_d;
            if (hi_trip)
                cmp_q <= 1'b1;  // R7
            else if (lo_trip)
                cmp_q <= 1'b0;  // R7
        end
    end

    // Interrupt latch: set wins over read or shutdown clear
    always_ff @(posedge CORE_CLK)
    begin
        if (rst)
        begin
            int_q    <= 1'b0;
            arm_lo_q <= 1'b0;
        end
        else if (conv_done && !arm_lo_q && hi_trip)
        begin
            int_q    <= 1'b1;  // R8
            arm_lo_q <= 1'b1;
        end
        else if (conv_done && arm_lo_q && lo_trip)
        begin
            int_q    <= 1'b1;  // R8
            arm_lo_q <= 1'b0;
        end
        else if (rd_temp || (st_q == tsc_pkg::ST_OFF))
            int_q <= 1'b0;  // R8
    end

    // ========================================================
    // Read data and alert pin
    always_comb
    begin
        case (ptr_q[1:0])  // R10
            tsc_pkg::SEL_TEMP:
                rd_word = em_q ? {temp_q, 3'h1}
                               : {temp_q[11:0], 4'h0};  // R13
            tsc_pkg::SEL_CFG:
                rd_word = {os_q, tsc_pkg::RES_FIX, fq_q, pol_q, tm_q,
                           sd_q, rate_q, cmp_q ^ !pol_q, em_q,
                           4'h0};  // R15 R19 R20
            tsc_pkg::SEL_LOW:
                rd_word = low_q;
            default:
                rd_word = high_q;
        endcase
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (rst)
        begin
            RD_DATA   <= 8'h00;
            ALERT     <= 1'b1;
            CONV_BUSY <= 1'b1;
        end
        else
        begin
            if (RD_STB)
                RD_DATA <= RD_FIRST ? rd_word[15:8]
                                    : rd_word[7:0];  // R12 R14
            ALERT     <= (tm_q ? int_q : cmp_q) ^ !pol_q;  // R17
            CONV_BUSY <= st_q == tsc_pkg::ST_CONV;
        end
    end

    // ========================================================
    // Assertions
    a_sel_reset: assert property (@(posedge CORE_CLK)  // R9
        $rose(RST_N) |-> ptr_q[1:0] == tsc_pkg::SEL_TEMP)
        else $error("select not cleared by reset");
    a_conv_start: assert property (@(posedge CORE_CLK)  // R1
        $rose(RST_N) |-> st_q == tsc_pkg::ST_CONV && ld_q)
        else $error("no conversion started after reset");
    a_alert_pol: assert property (@(posedge CORE_CLK)  // R17
        disable iff (rst) ##1 ALERT == ($past(tm_q ? int_q : cmp_q)
        ^ !$past(pol_q)))
        else $error("alert level wrong for polarity");
    a_res_fixed: assert property (@(posedge CORE_CLK)  // R19
        disable iff (rst) RD_STB && RD_FIRST
        && ptr_q[1:0] == tsc_pkg::SEL_CFG |=> RD_DATA[6:5] == 2'h3)
        else $error("resolution bits not 11");
    a_em_lsb: assert property (@(posedge CORE_CLK)  // R13
        disable iff (rst) RD_STB && !RD_FIRST && em_q
        && ptr_q[1:0] == tsc_pkg::SEL_TEMP |=> RD_DATA[0])
        else $error("extended format bit 0 not set");
    a_os_busy: assert property (@(posedge CORE_CLK)  // R5
        disable iff (rst) st_q == tsc_pkg::ST_OFF && sd_q && os_wr
        |=> !os_q && st_q == tsc_pkg::ST_CONV)
        else $error("one-shot did not start");
    a_shut_stop: assert property (@(posedge CORE_CLK)  // R4
        disable iff (rst) conv_done && sd_q |=> st_q == tsc_pkg::ST_OFF)
        else $error("shutdown not entered after conversion");
    a_msb_only: assert property (@(posedge CORE_CLK)  // R16
        disable iff (rst) wr_msb && ptr_q[1:0] == tsc_pkg::SEL_HIGH
        |=> high_q[7:0] == $past(high_q[7:0]))
        else $error("single byte write touched LSB");
    a_cmp_trip: assert property (@(posedge CORE_CLK)  // R7
        disable iff (rst) conv_done && fq_q == 2'h0
        && t_new >= lim_val(high_q, em_q) |=> cmp_q ##1 ALERT == pol_q
        || tm_q)
        else $error("comparator did not trip");
    a_int_clear: assert property (@(posedge CORE_CLK)  // R8
        disable iff (rst) rd_temp && !conv_done |=> !int_q)
        else $error("result read did not clear interrupt");

endmodule
`default_nettype wire

/* testbench/tsc_host_model.sv */
// Host model that reaches the sensor registers byte by byte
`timescale 1ns/1ps
`default_nettype none
module tsc_host_model
(
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    output logic            wr_stb,
    output logic            wr_ptr,
    output logic      [7:0] wr_data,
    output logic            rd_stb,
    output logic            rd_first
);
    // ========================================================
    // Idle bus at time zero
    initial
    begin
        wr_stb   = 1'b0;
        wr_ptr   = 1'b0;
        wr_data  = 8'h00;
        rd_stb   = 1'b0;
        rd_first = 1'b0;
    end

    // One write byte, held across one rising edge
    task automatic put(input logic ptr, input logic [7:0] b);
        wr_stb  = 1'b1;
        wr_ptr  = ptr;
        wr_data = b;
        @(negedge clk);
    endtask

    // Select byte, then n data bytes MSB first
    task automatic wr(input logic [1:0] sel, input int n,
                      input logic [15:0] v);
        put(1'b1, {6'h00, sel});
        if (n > 0)
            put(1'b0, v[15:8]);
        if (n > 1)
            put(1'b0, v[7:0]);
        wr_stb  = 1'b0;
        wr_ptr  = 1'b0;
        wr_data = ~wr_data; // Released byte never keeps its value
        @(negedge clk);
    endtask

    // Read n bytes at the current selection, MSB first
    task automatic rdb(input int n, output logic [15:0] v);
        v        = 16'h0000;
        rd_stb   = 1'b1;
        rd_first = 1'b1;
        @(negedge clk);
        v[15:8]  = rd_data;
        rd_first = 1'b0;
        if (n > 1)
        begin
            @(negedge clk);
            v[7:0] = rd_data;
        end
        rd_stb = 1'b0;
        @(negedge clk);
    endtask

    // Select a register, then read it
    task automatic rd(input logic [1:0] sel, input int n,
                      output logic [15:0] v);
        wr(sel, 0, 16'h0000);
        rdb(n, v);
    endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking testbench of the sensor control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int CV = 20;
    localparam int RT [4] = '{100, 60, 40, 30};
    logic        clk;
    logic        rst_n;
    logic        gc;
    logic [12:0] temp;
    logic [7:0]  rd_data;
    logic        alert;
    logic        busy;
    logic        wr_stb;
    logic        wr_ptr;
    logic [7:0]  wr_data;
    logic        rd_stb;
    logic        rd_first;
    logic [15:0] w;
    logic        ok;
    int          n_errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          seed;
    int          t0;

    // ========================================================
    // Design and host model
    tsc_sensor_ctl #(.CONV_CYCLES(28'(CV)), .RATE0_CYCLES(28'(RT[0])),
        .RATE1_CYCLES(28'(RT[1])), .RATE2_CYCLES(28'(RT[2])),
        .RATE3_CYCLES(28'(RT[3]))) dut (.CORE_CLK(clk), .RST_N(rst_n),
        .GC_RESET(gc), .WR_STB(wr_stb), .WR_PTR(wr_ptr),
        .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_FIRST(rd_first),
        .TEMP_IN(temp), .RD_DATA(rd_data), .ALERT(alert),
        .CONV_BUSY(busy));
    tsc_host_model host (.clk(clk), .rd_data(rd_data), .wr_stb(wr_stb),
        .wr_ptr(wr_ptr), .wr_data(wr_data), .rd_stb(rd_stb),
        .rd_first(rd_first));

    // Clock, 20 ns period
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Cycle stamp and hang limit
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            results();
        end
    end

    // ========================================================
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        if (got !== exp)
            n_errors++;
    endtask

    function automatic logic [15:0] fmt(input logic [12:0] t, input em);
        return em ? {t, 3'b001} : {t[11:0], 4'h0};
    endfunction

    function automatic logic [12:0] rnd(input logic [12:0] b, m);
        return b | (13'($random(seed)) & m);
    endfunction

    function automatic int nq(input int f);
        return f == 0 ? 1 : f == 1 ? 2 : f == 2 ? 4 : 6;
    endfunction

    // Wait for one whole fresh conversion and time it
    task automatic conv();
        @(negedge clk iff busy === 1'b0);
        @(negedge clk iff busy === 1'b1);
        t0 = cyc;
        @(negedge clk iff busy === 1'b0);
        chk(16'((cyc - t0) inside {[CV - 1:CV + 3]}), 16'h0001);
        repeat (3) @(negedge clk);
    endtask

    task automatic rise();
        @(negedge clk iff busy === 1'b0);
        @(negedge clk iff busy === 1'b1);
    endtask

    // No conversion may start for 150 cycles
    task automatic quiet();
        ok = 1'b1;
        repeat (150)
        begin
            @(negedge clk);
            if (busy !== 1'b0)
                ok = 1'b0;
        end
        chk(16'(ok), 16'h0001);
    endtask

    task automatic results();
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ========================================================
    // Main sequence
    initial
    begin
        seed = 9238;
        rst_n = 1'b0;
        gc = 1'b0;
        temp = rnd(13'h0000, 13'h03FF);
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t0 = cyc;
        chk(16'(busy), 16'h0001);
        host.rdb(2, w);
        chk(w, 16'h0000);
        @(negedge clk iff busy === 1'b0);
        chk(16'((cyc - t0) inside {[CV - 1:CV + 3]}), 16'h0001);
        host.rdb(2, w);
        chk(w, fmt(temp, 1'b0));
        host.rdb(1, w);
        chk(w, fmt(temp, 1'b0) & 16'hFF00);
        for (int s = 1; s < 4; s++)
        begin
            host.rd(2'(s), 2, w);
            chk(w, s == 1 ? 16'h60A0 : s == 2 ? tsc_pkg::LOW_RST :
                tsc_pkg::HIGH_RST);
        end
        host.wr(tsc_pkg::SEL_TEMP, 2, 16'hFFFF);
        host.rd(tsc_pkg::SEL_TEMP, 2, w);
        chk(w, fmt(temp, 1'b0));
        host.wr(tsc_pkg::SEL_HIGH, 2, 16'h5A50);
        host.wr(tsc_pkg::SEL_HIGH, 1, 16'h6400);
        host.rd(tsc_pkg::SEL_HIGH, 2, w);
        chk(w, 16'h6450);
        host.wr(tsc_pkg::SEL_HIGH, 2, 16'h5000);
        host.wr(tsc_pkg::SEL_CFG, 2, 16'h005F);
        host.rd(tsc_pkg::SEL_CFG, 2, w);
        chk(w, 16'h6070);
        temp = rnd(13'h0000, 13'h03FF);
        conv();
        host.rd(tsc_pkg::SEL_TEMP, 2, w);
        chk(w, fmt(temp, 1'b1));
        // Comparator alert over every queue depth, both polarities
        for (int f = 0; f < 4; f++)
        begin
            host.wr(tsc_pkg::SEL_CFG, 2, {3'b011, 2'(f), f[0], 2'b00, 8'hC0});
            for (int h = 1; h >= 0; h--)
            begin
                // Change the sample only between conversions
                @(negedge clk iff busy === 1'b1);
                @(negedge clk iff busy === 1'b0);
                temp = h ? rnd(13'h0500, 13'h00FF) : rnd(13'h0000, 13'h03FF);
                for (int i = 1; i <= nq(f); i++)
                begin
                    conv();
                    chk(16'(alert), 16'(!((h ? i == nq(f) : i < nq(f))
                        ^ f[0])));
                end
                host.rd(tsc_pkg::SEL_CFG, 2, w);
                chk(16'(w[5]), 16'(!(h[0] ^ f[0])));
            end
        end
        // Interrupt mode: hot, hold, clear, no refire, cold, clear
        host.wr(tsc_pkg::SEL_CFG, 2, 16'h62C0);
        for (int k = 0; k < 6; k++)
        begin
            if (k == 2 || k == 5)
            begin
                host.rd(tsc_pkg::SEL_TEMP, 1, w);
                repeat (3) @(negedge clk);
            end
            else
            begin
                temp = k < 4 ? rnd(13'h0500, 13'h00FF) : rnd(13'h0, 13'h3FF);
                conv();
            end
            chk(16'(alert), 16'(k > 1 && k != 4));
        end
        // Repetition rate of each code, start to start
        for (int c = 0; c < 4; c++)
        begin
            host.wr(tsc_pkg::SEL_CFG, 2, {8'h60, 2'(c), 6'h00});
            rise();
            rise();
            t0 = cyc;
            rise();
            chk(16'((cyc - t0) inside {[RT[c] - 2:RT[c] + 2]}), 16'h1);
        end
        // Shutdown, then one single conversion
        host.wr(tsc_pkg::SEL_CFG, 1, 16'h6100);
        @(negedge clk iff busy === 1'b0);
        quiet();
        temp = rnd(13'h0000, 13'h03FF);
        host.wr(tsc_pkg::SEL_CFG, 1, 16'hE100);
        chk(16'(busy), 16'h0001);
        host.rd(tsc_pkg::SEL_CFG, 1, w);
        chk(w, 16'h6100);
        @(negedge clk iff busy === 1'b0);
        host.rd(tsc_pkg::SEL_CFG, 1, w);
        chk(w, 16'hE100);
        host.rd(tsc_pkg::SEL_TEMP, 2, w);
        chk(w, fmt(temp, 1'b0));
        quiet();
        // General-call reset restores defaults and converts at once
        gc = 1'b1;
        @(negedge clk);
        gc = 1'b0;
        chk(16'(busy), 16'h0001);
        host.rd(tsc_pkg::SEL_CFG, 2, w);
        chk(w, 16'h60A0);
        results();
    end
endmodule
`default_nettype wire
